// file: design/asp_cfg.svh
// constants for the converter serial port: field positions, reset values, timing counts
`ifndef ASP_CFG_SVH
`define ASP_CFG_SVH
// command byte layout
`define ASP_CMD_SEL_HI     7
`define ASP_CMD_SEL_LO     6
`define ASP_CMD_READ_BIT   5
// register selects
`define ASP_SEL_SETUP      2'h0
`define ASP_SEL_CLOCK      2'h1
`define ASP_SEL_DATA       2'h2
// setup register fields
`define ASP_SETUP_GAIN_HI  5
`define ASP_SETUP_GAIN_LO  3
`define ASP_SETUP_BIPOLAR  2
`define ASP_SETUP_BUF_ON   1
`define ASP_SETUP_RST      8'h02
// clock register fields
`define ASP_CLK_OSC_OFF    4
`define ASP_CLK_RANGE      2
`define ASP_CLK_RATE_HI    1
`define ASP_CLK_RATE_LO    0
`define ASP_CLK_RST        8'h04
`define ASP_DATA_RST       16'h0000
// offset binary flips the sign bit
`define ASP_OFFSET_FLIP    16'h8000
// synchroniser reset levels {osc, reset_n, din, cs_n, sclk}
`define ASP_SYNC_RST       5'h0b
// bit counts
`define ASP_CMD_BITS       5'd8
`define ASP_BYTE_BITS      5'd8
`define ASP_WORD_BITS      5'd16
// timing
`define ASP_SYS_CLK_HZ     10000000
`define ASP_SCLK_MAX_HZ    5000000
`define ASP_SCLK_MIN_HALF  ((`ASP_SYS_CLK_HZ + 2 * `ASP_SCLK_MAX_HZ - 1) / (2 * `ASP_SCLK_MAX_HZ))
`define ASP_SCLK_HALF      3'd4
`define ASP_SAMPLE_PH      3'd2
`define ASP_HOST_RST_CYC   3'd4
`endif

// file: design/asp_pkg.sv
// types and shared decode for the converter serial port
`include "asp_cfg.svh"
package asp_pkg;
    typedef enum logic [2:0] {
        DEV_CMD   = 3'h1,
        DEV_WDATA = 3'h2,
        DEV_RDATA = 3'h4
    } asp_dev_state_t;

    typedef enum logic [4:0] {
        HST_IDLE = 5'h01,
        HST_LEAD = 5'h02,
        HST_LOW  = 5'h04,
        HST_HIGH = 5'h08,
        HST_TAIL = 5'h10
    } asp_hst_state_t;

    // data bits following a command byte
    function automatic logic [4:0] asp_data_bits(input logic [7:0] cmd);
        if (cmd[`ASP_CMD_SEL_HI:`ASP_CMD_SEL_LO] == `ASP_SEL_DATA && cmd[`ASP_CMD_READ_BIT])
            return `ASP_WORD_BITS;
        return `ASP_BYTE_BITS;
    endfunction : asp_data_bits
endpackage : asp_pkg

// file: design/asp_if.sv
// serial port wires between converter and host
`timescale 1ns/100ps
interface asp_if;
    logic sclk;
    logic cs_n;
    logic din;
    logic dout;
    logic dout_oe_n;
    logic result_ready_n_n;
    logic reset_n;
    wire  dout_line;
    // released line reads high, as with a pull-up
    assign dout_line = dout_oe_n ? 1'b1 : dout;
    modport dev  (input sclk, cs_n, din, reset_n, dout_line, output dout, dout_oe_n, result_ready_n_n);
    modport host (output sclk, cs_n, din, reset_n, input dout_line, dout_oe_n, result_ready_n_n);
endinterface : asp_if

// file: design/asp_dev.sv
// converter end of the serial port: shift logic, configuration, result ready, oscillator output
`timescale 1ns/100ps
`include "asp_cfg.svh"
module asp_dev
    import asp_pkg::*;
(
    input  wire logic        sys_clk_i,
    input  wire logic        rst_i,
    asp_if.dev               link,
    input  wire logic        osc_in_i,
    input  wire logic [15:0] raw_result_i,
    input  wire logic        raw_valid_i,
    output logic             osc_out_o,
    output logic             osc_out_oe_n_o,
    output logic [7:0]       gain_o,
    output logic             bipolar_o,
    output logic             buffer_on_o,
    output logic [9:0]       rate_hz_o
);
    logic [4:0]     sync1;
    logic [4:0]     sync2;
    logic           sclk_d;
    asp_dev_state_t state;
    asp_dev_state_t next_state;
    logic [4:0]     bit_cnt;
    logic [7:0]     cmd;
    logic [7:0]     shin;
    logic [15:0]    shout;
    logic [7:0]     setup;
    logic [7:0]     clkreg;
    logic [15:0]    data;
    logic           result_ready_n_n;
    logic           dout;
    logic           dout_oe_n;

    // filter notch per range and rate code
    function automatic logic [9:0] rate_decode(input logic range, input logic [1:0] code);
        logic [9:0] hz;
        hz = 10'd20;
        case ({range, code})
            3'h0: hz = 10'd20;
            3'h1: hz = 10'd25;
            3'h2: hz = 10'd100;
            3'h3: hz = 10'd200;
            3'h4: hz = 10'd50;
            3'h5: hz = 10'd60;
            3'h6: hz = 10'd250;
            default: hz = 10'd500;
        endcase
        return hz;
    endfunction : rate_decode

    // every pin from the host crosses two flops first
    wire [4:0] pins_in = {osc_in_i, link.reset_n, link.din, link.cs_n, link.sclk};
    genvar gi;
    generate
        for (gi = 0; gi < 5; gi++) begin : g_sync
            always_ff @(posedge sys_clk_i or posedge rst_i) begin
                if (rst_i) begin
                    sync1[gi] <= 1'(`ASP_SYNC_RST >> gi);
                    sync2[gi] <= 1'(`ASP_SYNC_RST >> gi);
                end else begin
                    sync1[gi] <= pins_in[gi];
                    sync2[gi] <= sync1[gi];
                end
            end
        end
    endgenerate

    // synchronised pins and decoded events
    wire       sclk_s    = sync2[0];
    wire       cs_n_s    = sync2[1];
    wire       din_s     = sync2[2];
    wire       soft_rst  = ~sync2[3];
    wire       osc_s     = sync2[4];
    wire       sclk_rise = sclk_s & ~sclk_d & ~cs_n_s;
    wire       sclk_fall = ~sclk_s & sclk_d & ~cs_n_s;
    wire [7:0] cmd_next  = {shin[6:0], din_s};
    wire [1:0] cmd_sel   = cmd_next[`ASP_CMD_SEL_HI:`ASP_CMD_SEL_LO];
    wire       cmd_done  = (state == DEV_CMD) && sclk_rise && (bit_cnt == `ASP_CMD_BITS - 5'd1);
    wire       cmd_read  = cmd_next[`ASP_CMD_READ_BIT];
    wire       wr_done   = (state == DEV_WDATA) && sclk_rise && (bit_cnt == `ASP_BYTE_BITS - 5'd1);
    wire [1:0] cur_sel   = cmd[`ASP_CMD_SEL_HI:`ASP_CMD_SEL_LO];
    wire       rd_done   = (state == DEV_RDATA) && sclk_rise && (bit_cnt == asp_data_bits(cmd) - 5'd1);
    wire       data_read = rd_done && (cur_sel == `ASP_SEL_DATA);
    wire [15:0] rd_word  = (cmd_sel == `ASP_SEL_DATA)  ? data :
                           (cmd_sel == `ASP_SEL_CLOCK) ? {clkreg, 8'h00} : {setup, 8'h00};
    wire [15:0] coded    = setup[`ASP_SETUP_BIPOLAR] ? (raw_result_i ^ `ASP_OFFSET_FLIP)
                                                     : raw_result_i;

    // transfer sequencing
    always_comb begin
        next_state = state;
        case (state)
            DEV_CMD: begin
                if (cmd_done)
                    next_state = cmd_read ? DEV_RDATA : DEV_WDATA;
            end
            DEV_WDATA: begin
                if (wr_done)
                    next_state = DEV_CMD;
            end
            DEV_RDATA: begin
                if (rd_done)
                    next_state = DEV_CMD;
            end
            default: next_state = DEV_CMD;
        endcase
        if (cs_n_s)
            next_state = DEV_CMD;
    end

    // state, counter and shift registers; raised select aborts a transfer
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            state   <= DEV_CMD;
            sclk_d  <= 1'b1;
            bit_cnt <= 5'd0;
            cmd     <= 8'h00;
            shin    <= 8'h00;
            shout   <= 16'h0000;
        end else if (soft_rst) begin
            state   <= DEV_CMD;
            sclk_d  <= sclk_s;
            bit_cnt <= 5'd0;
            cmd     <= 8'h00;
            shin    <= 8'h00;
            shout   <= 16'h0000;
        end else begin
            state  <= next_state;
            sclk_d <= sclk_s;
            if (cs_n_s || cmd_done || wr_done || rd_done)
                bit_cnt <= 5'd0;
            else if (sclk_rise) // framing by bit count, so a tied-low select still works
                bit_cnt <= bit_cnt + 5'd1;
            if (sclk_rise)
                shin <= cmd_next;
            if (cmd_done)
                cmd <= cmd_next;
            if (cmd_done && cmd_read)
                shout <= rd_word;
            else if (sclk_fall && state == DEV_RDATA)
                shout <= {shout[14:0], 1'b0};
        end
    end

    // configuration and result registers
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            setup  <= `ASP_SETUP_RST;
            clkreg <= `ASP_CLK_RST;
            data   <= `ASP_DATA_RST;
        end else if (soft_rst) begin
            setup  <= `ASP_SETUP_RST;
            clkreg <= `ASP_CLK_RST;
            data   <= `ASP_DATA_RST;
        end else begin
            if (wr_done && cur_sel == `ASP_SEL_SETUP)
                setup <= cmd_next;
            if (wr_done && cur_sel == `ASP_SEL_CLOCK)
                clkreg <= cmd_next;
            if (raw_valid_i)
                data <= coded;
        end
    end

    // ready flag: a new result wins over a finishing read in the same cycle
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i)
            result_ready_n_n <= 1'b1;
        else if (soft_rst)
            result_ready_n_n <= 1'b1;
        else if (raw_valid_i)
            result_ready_n_n <= 1'b0;
        else if (data_read)
            result_ready_n_n <= 1'b1;
    end

    // serial output line; bit moves only on a falling edge, and is cleared to 0 on deselect or pin reset
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            dout      <= 1'b0;
            dout_oe_n <= 1'b1;
        end else begin
            dout_oe_n <= cs_n_s | soft_rst;
            if (soft_rst || cs_n_s)
                dout <= 1'b0;
            else if (sclk_fall && state == DEV_RDATA)
                dout <= shout[15];
        end
    end

    // oscillator output and decoded settings; registered so every output is a flop
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            osc_out_o      <= 1'b0;
            osc_out_oe_n_o <= 1'b1;
            gain_o         <= 8'h01;
            bipolar_o      <= 1'b0;
            buffer_on_o    <= 1'b0;
            rate_hz_o      <= 10'd20;
        end else begin
            osc_out_oe_n_o <= clkreg[`ASP_CLK_OSC_OFF];
            osc_out_o      <= ~osc_s & ~clkreg[`ASP_CLK_OSC_OFF];
            gain_o         <= 8'h01 << setup[`ASP_SETUP_GAIN_HI:`ASP_SETUP_GAIN_LO];
            bipolar_o      <= setup[`ASP_SETUP_BIPOLAR];
            buffer_on_o    <= setup[`ASP_SETUP_BUF_ON];
            rate_hz_o      <= rate_decode(clkreg[`ASP_CLK_RANGE],
                                          clkreg[`ASP_CLK_RATE_HI:`ASP_CLK_RATE_LO]);
        end
    end

    // pin drivers
    assign link.dout      = dout;
    assign link.dout_oe_n = dout_oe_n;
    assign link.result_ready_n_n    = result_ready_n_n;
endmodule : asp_dev

// file: design/asp_host.sv
// host end of the serial port: shift clock divider, framing and readback
`timescale 1ns/100ps
`include "asp_cfg.svh"
module asp_host
    import asp_pkg::*;
(
    input  wire logic        sys_clk_i,
    input  wire logic        rst_i,
    asp_if.host              link,
    input  wire logic        cmd_valid_i,
    input  wire logic [7:0]  cmd_i,
    input  wire logic [7:0]  wdata_i,
    input  wire logic        dev_reset_i,
    output logic             cmd_ready_o,
    output logic [15:0]      rd_data_o,
    output logic             rd_valid_o,
    output logic             result_ready_o
);
    asp_hst_state_t state;
    logic [2:0]     ph;
    logic [4:0]     bit_cnt;
    logic [4:0]     total;
    logic [15:0]    tx;
    logic [15:0]    rx;
    logic           is_read;
    logic [1:0]     dout_sync;
    logic [1:0]     result_ready_n_sync;
    logic [2:0]     rst_cnt;
    logic           sclk;
    logic           cs_n;
    logic           din;
    logic           reset_n;

    // half period must stay above the minimum for the top shift rate
    wire ph_end   = (ph == `ASP_SCLK_HALF - 3'd1);
    wire last_bit = (bit_cnt == total - 5'd1);
    wire start    = (state == HST_IDLE) && cmd_valid_i && (rst_cnt == 3'd0) && !dev_reset_i;

    // returning pins cross two flops
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            dout_sync <= 2'h0;
            result_ready_n_sync <= 2'h3;
        end else begin
            dout_sync <= {dout_sync[0], link.dout_line};
            result_ready_n_sync <= {result_ready_n_sync[0], link.result_ready_n_n};
        end
    end

    // device reset pulse, held long enough for the far synchroniser
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            rst_cnt <= 3'd0;
            reset_n <= 1'b1;
        end else if (dev_reset_i && state == HST_IDLE) begin
            rst_cnt <= `ASP_HOST_RST_CYC;
            reset_n <= 1'b0;
        end else if (rst_cnt != 3'd0) begin
            rst_cnt <= rst_cnt - 3'd1;
            reset_n <= (rst_cnt == 3'd1);
        end
    end

    // framing: select low across the whole transfer, clock idles high
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            state   <= HST_IDLE;
            ph      <= 3'd0;
            bit_cnt <= 5'd0;
            total   <= 5'd0;
            tx      <= 16'h0000;
            rx      <= 16'h0000;
            is_read <= 1'b0;
            sclk    <= 1'b1;
            cs_n    <= 1'b1;
            din     <= 1'b0;
        end else begin
            ph <= (state == HST_IDLE || ph_end) ? 3'd0 : ph + 3'd1;
            case (state)
                HST_IDLE: begin
                    if (start) begin
                        state   <= HST_LEAD;
                        cs_n    <= 1'b0;
                        tx      <= {cmd_i, wdata_i};
                        is_read <= cmd_i[`ASP_CMD_READ_BIT];
                        total   <= `ASP_CMD_BITS + asp_data_bits(cmd_i);
                        bit_cnt <= 5'd0;
                        rx      <= 16'h0000;
                    end
                end
                HST_LEAD, HST_HIGH: begin
                    if (state == HST_HIGH && ph == `ASP_SAMPLE_PH)
                        rx <= {rx[14:0], dout_sync[1]};
                    if (ph_end) begin
                        if (state == HST_HIGH && last_bit) begin
                            state <= HST_TAIL;
                        end else begin
                            state <= HST_LOW;
                            sclk  <= 1'b0;
                            din   <= tx[15];
                            tx    <= {tx[14:0], 1'b0};
                        end
                        if (state == HST_HIGH)
                            bit_cnt <= bit_cnt + 5'd1;
                    end
                end
                HST_LOW: begin
                    if (ph_end) begin
                        state <= HST_HIGH;
                        sclk  <= 1'b1;
                    end
                end
                HST_TAIL: begin
                    if (ph_end) begin
                        state <= HST_IDLE;
                        cs_n  <= 1'b1;
                    end
                end
                default: state <= HST_IDLE;
            endcase
        end
    end

    // user-side answers
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            cmd_ready_o    <= 1'b0;
            rd_data_o      <= 16'h0000;
            rd_valid_o     <= 1'b0;
            result_ready_o <= 1'b0;
        end else begin
            cmd_ready_o    <= (state == HST_IDLE) && !start && (rst_cnt == 3'd0) && !dev_reset_i;
            rd_valid_o     <= (state == HST_TAIL) && ph_end && is_read;
            result_ready_o <= ~result_ready_n_sync[1];
            if (state == HST_TAIL && ph_end && is_read)
                rd_data_o <= (total == `ASP_CMD_BITS + `ASP_WORD_BITS) ? rx : {8'h00, rx[7:0]};
        end
    end

    // pin drivers
    assign link.sclk    = sclk;
    assign link.cs_n    = cs_n;
    assign link.din     = din;
    assign link.reset_n = reset_n;
endmodule : asp_host

// file: sim/asp_sva.sv
// concurrent checks on the serial link between the host and converter ends
`timescale 1ns/100ps
module asp_sva (
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic din,
    input wire logic dout,
    input wire logic dout_oe_n,
    input wire logic result_ready_n_n,
    input wire logic reset_n
);
    logic       sclk_q;
    logic [4:0] rise_cnt;

    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (rst_i);

    // rising shift edges seen in the current frame, cleared while deselected
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            sclk_q   <= 1'b1;
            rise_cnt <= 5'h00;
        end else begin
            sclk_q   <= sclk;
            rise_cnt <= cs_n ? 5'h00 : rise_cnt + 5'(sclk & ~sclk_q);
        end
    end

    a_frame_bit_count: assert property ($rose(cs_n) |-> rise_cnt == 5'h10 || rise_cnt == 5'h18)
        else $error("frame did not carry 16 or 24 shift clocks");
    a_sclk_half_len: assert property ($changed(sclk) |=> $stable(sclk)[*3])
        else $error("shift clock half period under four cycles");
    a_select_holds: assert property ($rose(sclk) && !cs_n |=> !cs_n[*3])
        else $error("select released during a shift clock high half");
    a_release_deselect: assert property (cs_n[*5] |-> dout_oe_n)
        else $error("serial output driven while deselected");
    a_reset_pin_clears: assert property (!reset_n[*4] |=> result_ready_n_n && dout_oe_n)
        else $error("reset pin did not clear ready and output");
    a_ready_after_read: assert property ($rose(result_ready_n_n) |-> (!cs_n && sclk) || !reset_n || !$past(reset_n, 3))
        else $error("ready released outside a completed read");
    a_dout_on_fall: assert property ($changed(dout) && !dout_oe_n && !$past(dout_oe_n) |-> !sclk)
        else $error("serial output changed while shift clock high");
    a_din_setup: assert property ($rose(sclk) |-> $stable(din))
        else $error("serial input moved at the sampling edge");
endmodule : asp_sva

// file: sim/adc_serial_port_ctrl_tb.sv
// self-checking bench: host and converter ends joined over the serial link
`timescale 1ns/100ps
module adc_serial_port_ctrl_tb;
    logic        sys_clk_i;
    logic        rst_i;
    logic        osc_in_i;
    logic [15:0] raw_result_i;
    logic        raw_valid_i;
    logic        cmd_valid_i;
    logic [7:0]  cmd_i;
    logic [7:0]  wdata_i;
    logic        dev_reset_i;
    logic        cmd_ready_o;
    logic [15:0] rd_data_o;
    logic        rd_valid_o;
    logic        result_ready_o;
    logic        osc_out_o;
    logic        osc_out_oe_n_o;
    logic [7:0]  gain_o;
    logic        bipolar_o;
    logic        buffer_on_o;
    logic [9:0]  rate_hz_o;
    int          n_fail = 0;
    int          cmp_count = 0;

    asp_if link ();
    asp_dev asp_dev_inst (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .link(link), .osc_in_i(osc_in_i),
        .raw_result_i(raw_result_i), .raw_valid_i(raw_valid_i), .osc_out_o(osc_out_o),
        .osc_out_oe_n_o(osc_out_oe_n_o), .gain_o(gain_o), .bipolar_o(bipolar_o),
        .buffer_on_o(buffer_on_o), .rate_hz_o(rate_hz_o));
    asp_host asp_host_inst (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .link(link), .cmd_valid_i(cmd_valid_i),
        .cmd_i(cmd_i), .wdata_i(wdata_i), .dev_reset_i(dev_reset_i), .cmd_ready_o(cmd_ready_o),
        .rd_data_o(rd_data_o), .rd_valid_o(rd_valid_o), .result_ready_o(result_ready_o));
    asp_sva asp_sva_inst (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .sclk(link.sclk), .cs_n(link.cs_n),
        .din(link.din), .dout(link.dout), .dout_oe_n(link.dout_oe_n), .result_ready_n_n(link.result_ready_n_n),
        .reset_n(link.reset_n));

    // 10 MHz system clock
    initial begin
        sys_clk_i = 1'b0;
        forever #50 sys_clk_i = ~sys_clk_i;
    end

    task automatic summarize();
        $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : summarize

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // one framed transfer; waits on ready both ways so a stuck frame is caught
    task automatic xfer(input logic [7:0] cmd, input logic [7:0] wd, output logic [15:0] rd);
        int n;
        rd = 16'hxxxx;
        n = 0;
        while (cmd_ready_o !== 1'b1 && n < 400) begin
            @(negedge sys_clk_i);
            n++;
        end
        cmd_valid_i = 1'b1;
        cmd_i = cmd;
        wdata_i = wd;
        @(negedge sys_clk_i);
        cmd_valid_i = 1'b0;
        @(negedge sys_clk_i);
        n = 0;
        while (cmd_ready_o !== 1'b1 && n < 400) begin
            @(negedge sys_clk_i);
            if (rd_valid_o === 1'b1)
                rd = rd_data_o;
            n++;
        end
        if (n >= 400)
            check(16'h0001, 16'h0000);
    endtask : xfer

    task automatic t_defaults();
        logic [15:0] rd;
        check(16'(gain_o), 16'h0001);
        check(16'(buffer_on_o), 16'h0001);
        check(16'(rate_hz_o), 16'h0032);
        check(16'(osc_out_oe_n_o), 16'h0000);
        xfer(8'h20, 8'h00, rd);
        check(rd, 16'h0002);
        xfer(8'h60, 8'h00, rd);
        check(rd, 16'h0004);
    endtask : t_defaults

    // every gain code, alternating coding and buffer, with readback
    task automatic t_setup();
        logic [15:0] rd;
        logic [7:0]  wd;
        for (int g = 0; g < 8; g++) begin
            wd = {2'h0, 3'(g), g[0], ~g[0], 1'b0};
            xfer(8'h00, wd, rd);
            check(16'(gain_o), 16'h0001 << g);
            check(16'(bipolar_o), 16'(g[0]));
            check(16'(buffer_on_o), {15'h0000, ~g[0]});
            xfer(8'h20, 8'h00, rd);
            check(rd, 16'(wd));
        end
    endtask : t_setup

    task automatic t_rate();
        logic [15:0] rd;
        logic [9:0]  rates [8] = '{10'h014, 10'h019, 10'h064, 10'h0c8, 10'h032, 10'h03c, 10'h0fa, 10'h1f4};
        for (int c = 0; c < 8; c++) begin
            xfer(8'h40, {5'h00, 3'(c)}, rd);
            check(16'(rate_hz_o), 16'(rates[c]));
        end
    endtask : t_rate

    task automatic t_osc();
        logic [15:0] rd;
        xfer(8'h40, 8'h14, rd);
        osc_in_i = 1'b1;
        repeat (6) @(negedge sys_clk_i);
        check(16'(osc_out_oe_n_o), 16'h0001);
        check(16'(osc_out_o), 16'h0000);
        xfer(8'h40, 8'h04, rd);
        for (int i = 0; i < 4; i++) begin
            osc_in_i = ~osc_in_i;
            repeat (6) @(negedge sys_clk_i);
            check(16'(osc_out_o), {15'h0000, ~osc_in_i});
        end
        check(16'(osc_out_oe_n_o), 16'h0000);
    endtask : t_osc

    // a fresh result raises ready; a full word read drops it again
    task automatic t_data(input logic bip, input logic [15:0] val);
        logic [15:0] rd;
        xfer(8'h00, {5'h00, bip, 2'h2}, rd);
        raw_result_i = val;
        raw_valid_i = 1'b1;
        @(negedge sys_clk_i);
        raw_valid_i = 1'b0;
        repeat (5) @(negedge sys_clk_i);
        check(16'(result_ready_o), 16'h0001);
        xfer(8'ha0, 8'h00, rd);
        check(rd, bip ? val ^ 16'h8000 : val);
        repeat (4) @(negedge sys_clk_i);
        check(16'(result_ready_o), 16'h0000);
    endtask : t_data

    // pin reset with a pending result and odd setup must restore power-on state
    task automatic t_soft_reset();
        logic [15:0] rd;
        xfer(8'h00, 8'h3c, rd);
        raw_valid_i = 1'b1;
        @(negedge sys_clk_i);
        raw_valid_i = 1'b0;
        dev_reset_i = 1'b1;
        @(negedge sys_clk_i);
        dev_reset_i = 1'b0;
        repeat (12) @(negedge sys_clk_i);
        check(16'(result_ready_o), 16'h0000);
        check(16'(gain_o), 16'h0001);
        xfer(8'h20, 8'h00, rd);
        check(rd, 16'h0002);
    endtask : t_soft_reset

    initial begin
        rst_i = 1'b1;
        osc_in_i = 1'b0;
        raw_result_i = 16'h0000;
        raw_valid_i = 1'b0;
        cmd_valid_i = 1'b0;
        cmd_i = 8'h00;
        wdata_i = 8'h00;
        dev_reset_i = 1'b0;
        repeat (4) @(negedge sys_clk_i);
        rst_i = 1'b0;
        @(negedge sys_clk_i);
        t_defaults();
        t_setup();
        t_rate();
        t_osc();
        t_data(1'b0, 16'hc35a);
        t_data(1'b1, 16'h1e0f);
        t_soft_reset();
        summarize();
    end

    // 34 frames are expected; this leaves ample margin
    initial begin
        repeat (30000) @(posedge sys_clk_i);
        n_fail++;
        summarize();
    end
endmodule : adc_serial_port_ctrl_tb
